// ==== rtl/carry_timer.sv ====
`timescale 1ns/1ps
module carry_timer #(
  parameter int unsigned MS_CYCLES = reset_ctrl_pkg::MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic init,
  input wire logic sel_wr,
  input wire logic [3:0] sel_data,
  output logic carry_pulse,
  output logic [3:0] tick_period
);

  logic [16:0] pre;
  logic [7:0] ms_cnt;
  logic pre_wrap;
  logic period_end;

  // Prescaler wrap marks the end of one millisecond of running clock.
  assign pre_wrap = run && (pre == 17'(MS_CYCLES - 1));
  assign period_end = ms_cnt >= (reset_ctrl_pkg::sel_to_ms(tick_period) - 8'h01);

  // Tick period select keeps its value unless written, or cleared by reset or the partial init.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || init) begin
      tick_period <= reset_ctrl_pkg::TICK_PERIOD_RST; // RULE13
    end else if (sel_wr) begin
      tick_period <= sel_data; // RULE10
    end
  end

  // Millisecond prescaler runs only while the oscillator runs.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || init) begin
      pre <= 17'h00000;
    end else if (pre_wrap) begin
      pre <= 17'h00000;
    end else if (run) begin
      pre <= pre + 17'h00001;
    end
  end

  // Carry counter starts half way so the first carry follows by the start delay.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || init) begin
      ms_cnt <= reset_ctrl_pkg::CARRY_PRESET; // RULE16
    end else if (pre_wrap) begin
      ms_cnt <= period_end ? 8'h00 : ms_cnt + 8'h01;
    end
  end

  // Carry set pulse lasts one cycle at the end of each period.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      carry_pulse <= 1'b0;
    end else begin
      carry_pulse <= pre_wrap && period_end;
    end
  end

endmodule

// ==== rtl/reset_controller.sv ====
`timescale 1ns/1ps
// What this block does
// (RULE1) Two reset sources: low supply power-on reset and chip-enable rise.
// (RULE2) Chip-enable reset starts on a low-to-high edge of the chip-enable input.
// (RULE3) Power-on reset initialises everything and restarts execution at address zero.
// (RULE4) Chip-enable reset initialises core state and part of control, restarts at zero.
// (RULE5) Halt-entry strobe on power-on and clock stop only; halt ends at carry.
// (RULE6) Partial-init strobe on power-on and clock stop only.
// (RULE7) Full-init strobe on chip-enable reset, power-on reset and clock stop.
// (RULE8) The clock-stop instruction also triggers the reset sequencer.
// (RULE9) After chip-enable rise, full-init fires at the next carry pulse; the code fires none when the rise comes in clock stop.
// (RULE10) Without clock stop the tick period keeps its selected carry period.
// (RULE11) Program runs normally between chip-enable rise and the aligned reset.
// (RULE12) Clock-stop instruction raises all three strobes at once.
// (RULE13) Partial-init clears tick period to zero, the 100 ms carry period.
// (RULE14) With chip enable low after clock stop, halt holds and oscillator stops.
// (RULE15) Chip-enable rise in clock stop restarts the oscillator.
// (RULE16) After clock stop, execution restarts at the first carry, about 50 ms later.
// (RULE17) Chip-enable reset cuts in regardless of the instruction being executed.
// (RULE18) Low supply holds all three strobes; they release together when it clears.
// (RULE19) After supply recovery, execution restarts about 50 ms later at first carry.
// (RULE20) Chip-enable input passes a two-flop synchroniser before edge detection.
module reset_controller #(
  parameter int unsigned MS_CYCLES = reset_ctrl_pkg::MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce_pin,
  input wire logic low_supply_flag,
  input wire logic stop_exec,
  input wire logic tick_period_wr,
  input wire logic [3:0] tick_period_wdata,
  output logic halt_entry_strobe,
  output logic partial_init_strobe,
  output logic full_init_strobe,
  output logic halt_active,
  output logic osc_enable,
  output logic exec_start,
  output logic carry_pulse,
  output logic [3:0] tick_period
);

  reset_ctrl_pkg::seq_state_e state;
  reset_ctrl_pkg::seq_state_e next_state;

  logic ce_meta;
  logic ce_sync;
  logic ce_prev;
  logic ce_rise;
  logic supply_meta;
  logic supply_low;
  logic ce_pending;
  logic next_ce_pending;
  logic next_halt_entry;
  logic next_partial_init;
  logic next_full_init;
  logic next_exec_start;
  logic next_halt_active;
  logic next_osc_enable;

  // Two-flop synchroniser for the chip-enable pin; only the second flop is read.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ce_meta <= 1'b0;
      ce_sync <= 1'b0;
    end else begin
      ce_meta <= ce_pin; // RULE20
      ce_sync <= ce_meta; // RULE20
    end
  end

  // Previous synchronised level for rising edge detection.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ce_prev <= 1'b0;
    end else begin
      ce_prev <= ce_sync;
    end
  end

  // A chip-enable reset is requested only by a low-to-high transition.
  assign ce_rise = ce_sync && !ce_prev; // RULE2

  // The low supply flag comes from the analog detector and is synchronised too.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      supply_meta <= 1'b0;
      supply_low <= 1'b0;
    end else begin
      supply_meta <= low_supply_flag;
      supply_low <= supply_meta;
    end
  end

  // Basic timer that produces the carry set pulse and holds the tick period.
  carry_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_carry_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(osc_enable),
    .init(partial_init_strobe),
    .sel_wr(tick_period_wr),
    .sel_data(tick_period_wdata),
    .carry_pulse(carry_pulse),
    .tick_period(tick_period)
  );

  // Sequencer decisions: which strobes fire and where the sequence goes next.
  always_comb begin
    next_state = state;
    next_ce_pending = ce_pending;
    next_halt_entry = 1'b0;
    next_partial_init = 1'b0;
    next_full_init = 1'b0;
    next_exec_start = 1'b0;
    if (supply_low) begin
      // Low supply overrides everything and holds all three strobes.
      next_state = reset_ctrl_pkg::ST_SUPPLY_LOW; // RULE1
      next_halt_entry = 1'b1; // RULE18
      next_partial_init = 1'b1; // RULE18
      next_full_init = 1'b1; // RULE3
      next_ce_pending = 1'b0;
    end else begin
      case (state)
        reset_ctrl_pkg::ST_SUPPLY_LOW: begin
          // Strobes drop together; the timer was preset so the carry comes later.
          next_state = reset_ctrl_pkg::ST_HALT_WAIT; // RULE19
        end
        reset_ctrl_pkg::ST_RUN: begin
          if (stop_exec) begin
            next_halt_entry = 1'b1; // RULE12
            next_partial_init = 1'b1; // RULE6
            next_full_init = 1'b1; // RULE8
            next_state = ce_sync ? reset_ctrl_pkg::ST_HALT_WAIT
                                 : reset_ctrl_pkg::ST_STOPPED; // RULE14
          end else if (ce_rise) begin
            // Execution continues until the next carry pulse.
            next_state = reset_ctrl_pkg::ST_CE_WAIT; // RULE11
          end
        end
        reset_ctrl_pkg::ST_CE_WAIT: begin
          if (stop_exec) begin
            next_halt_entry = 1'b1; // RULE12
            next_partial_init = 1'b1; // RULE6
            next_full_init = 1'b1; // RULE7
            next_state = ce_sync ? reset_ctrl_pkg::ST_HALT_WAIT
                                 : reset_ctrl_pkg::ST_STOPPED; // RULE14
          end else if (carry_pulse) begin
            // The reset cuts in whatever instruction is running.
            next_full_init = 1'b1; // RULE9
            next_exec_start = 1'b1; // RULE17
            next_state = reset_ctrl_pkg::ST_RUN; // RULE4
          end
        end
        reset_ctrl_pkg::ST_STOPPED: begin
          if (ce_rise) begin
            next_state = reset_ctrl_pkg::ST_HALT_WAIT; // RULE15
          end
        end
        reset_ctrl_pkg::ST_HALT_WAIT: begin
          if (carry_pulse) begin
            // Halt is released by the carry and execution restarts at zero.
            next_full_init = ce_pending || ce_rise; // RULE9
            next_exec_start = 1'b1; // RULE5
            next_ce_pending = 1'b0;
            next_state = reset_ctrl_pkg::ST_RUN; // RULE16
          end else if (ce_rise) begin
            next_ce_pending = 1'b1; // RULE2
          end
        end
        default: begin
          next_state = reset_ctrl_pkg::ST_HALT_WAIT;
          next_ce_pending = 1'b0;
        end
      endcase
    end
  end

  // Halt and oscillator levels follow the state that is entered.
  always_comb begin
    case (next_state)
      reset_ctrl_pkg::ST_STOPPED: begin
        next_halt_active = 1'b1; // RULE14
        next_osc_enable = 1'b0; // RULE14
      end
      reset_ctrl_pkg::ST_SUPPLY_LOW: begin
        next_halt_active = 1'b1;
        next_osc_enable = 1'b0;
      end
      reset_ctrl_pkg::ST_HALT_WAIT: begin
        next_halt_active = 1'b1; // RULE5
        next_osc_enable = 1'b1; // RULE15
      end
      default: begin
        next_halt_active = 1'b0;
        next_osc_enable = 1'b1;
      end
    endcase
  end

  // Sequencer state; reset behaves like the end of a power-on reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= reset_ctrl_pkg::ST_HALT_WAIT;
      ce_pending <= 1'b0;
    end else begin
      state <= next_state;
      ce_pending <= next_ce_pending;
    end
  end

  // Registered reset strobes toward the core.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      halt_entry_strobe <= 1'b0;
      partial_init_strobe <= 1'b0;
      full_init_strobe <= 1'b0;
      exec_start <= 1'b0;
    end else begin
      halt_entry_strobe <= next_halt_entry;
      partial_init_strobe <= next_partial_init;
      full_init_strobe <= next_full_init;
      exec_start <= next_exec_start;
    end
  end

  // Registered halt and oscillator controls.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      halt_active <= 1'b1;
      osc_enable <= 1'b1;
    end else begin
      halt_active <= next_halt_active;
      osc_enable <= next_osc_enable;
    end
  end

endmodule

// ==== rtl/reset_ctrl_pkg.sv ====
package reset_ctrl_pkg;

  // Clock and the length of the one millisecond tick in cycles.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_TIME_NS = 1000000;
  localparam int unsigned MS_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // Carry periods that the tick period select can choose, in milliseconds.
  localparam logic [7:0] PERIOD_1MS = 8'h01;
  localparam logic [7:0] PERIOD_5MS = 8'h05;
  localparam logic [7:0] PERIOD_100MS = 8'h64;
  localparam logic [7:0] PERIOD_250MS = 8'hfa;

  // Delay from halt release arming to the first carry, in milliseconds.
  localparam logic [7:0] START_DELAY_MS = 8'h32;
  localparam logic [7:0] CARRY_PRESET = PERIOD_100MS - START_DELAY_MS;

  // Codes of the tick period select field and its reset value.
  localparam logic [3:0] TICK_SEL_100MS = 4'h0;
  localparam logic [3:0] TICK_SEL_250MS = 4'h1;
  localparam logic [3:0] TICK_SEL_5MS = 4'h2;
  localparam logic [3:0] TICK_SEL_1MS = 4'h3;
  localparam logic [3:0] TICK_PERIOD_RST = TICK_SEL_100MS;

  // States of the reset sequencer.
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_CE_WAIT = 3'b001,
    ST_STOPPED = 3'b010,
    ST_HALT_WAIT = 3'b011,
    ST_SUPPLY_LOW = 3'b100
  } seq_state_e;

  // Maps a tick period code to its carry period in milliseconds.
  function automatic logic [7:0] sel_to_ms(input logic [3:0] sel);
    logic [7:0] ms;
    ms = PERIOD_100MS;
    case (sel)
      TICK_SEL_250MS: ms = PERIOD_250MS;
      TICK_SEL_5MS: ms = PERIOD_5MS;
      TICK_SEL_1MS: ms = PERIOD_1MS;
      default: ms = PERIOD_100MS;
    endcase
    return ms;
  endfunction

endpackage

// ==== testbench/ce_host.sv ====
`timescale 1ns/1ps
// Host end of the chip-enable line, driving the pin away from the clock edge.
module ce_host (
  input wire logic want,
  output wire logic ce_pin
);
  // A rise of the pin is the host's request for a reset.
  assign #3 ce_pin = want;
endmodule

// ==== testbench/reset_controller_properties.sv ====
`timescale 1ns/1ps
// Watches strobe, halt, oscillator and tick period timing at the sequencer ports.
module rc_props #(
  parameter int unsigned MS_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce_pin,
  input wire logic low_supply_flag,
  input wire logic stop_exec,
  input wire logic tick_period_wr,
  input wire logic [3:0] tick_period_wdata,
  input wire logic halt_entry_strobe,
  input wire logic partial_init_strobe,
  input wire logic full_init_strobe,
  input wire logic halt_active,
  input wire logic osc_enable,
  input wire logic exec_start,
  input wire logic carry_pulse,
  input wire logic [3:0] tick_period
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_stop_strobes: assert property (
    stop_exec && !halt_active |=> halt_entry_strobe && partial_init_strobe && full_init_strobe)
    else $error("stop without all strobes");
  a_strobe_group: assert property (
    halt_entry_strobe || partial_init_strobe |->
    halt_entry_strobe && partial_init_strobe && full_init_strobe)
    else $error("strobes not grouped");
  a_ce_at_carry: assert property (
    full_init_strobe && !halt_entry_strobe |-> exec_start && $past(carry_pulse))
    else $error("chip-enable reset off carry");
  a_start_carry: assert property (
    exec_start |-> $past(carry_pulse) && !halt_active)
    else $error("start not after carry");
  a_supply_hold: assert property (
    low_supply_flag [*4] |-> halt_entry_strobe && full_init_strobe && !osc_enable)
    else $error("low supply not held");
  a_tick_clear: assert property (
    partial_init_strobe |=> tick_period == reset_ctrl_pkg::TICK_SEL_100MS)
    else $error("tick period not cleared");
  a_tick_write: assert property (
    tick_period_wr && !partial_init_strobe |=> tick_period == $past(tick_period_wdata))
    else $error("tick period not written");
  a_stop_osc: assert property (
    !ce_pin [*3] ##0 stop_exec && !halt_active |=> !osc_enable)
    else $error("oscillator still on");
  a_ce_wakes: assert property (
    !osc_enable && !ce_pin ##1 (ce_pin && !low_supply_flag) [*6] |-> osc_enable)
    else $error("oscillator not restarted");
  c_ce_reset: cover property (full_init_strobe && !halt_entry_strobe);
  c_stop: cover property (stop_exec && !halt_active);
  c_supply: cover property (low_supply_flag [*4]);
endmodule

bind reset_controller rc_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .sys_clk, .rst_n, .ce_pin, .low_supply_flag, .stop_exec, .tick_period_wr,
  .tick_period_wdata, .halt_entry_strobe, .partial_init_strobe, .full_init_strobe,
  .halt_active, .osc_enable, .exec_start, .carry_pulse, .tick_period
);

// ==== testbench/reset_controller_tb.sv ====
`timescale 1ns/1ps
module reset_controller_tb;
  localparam int unsigned MS = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce_want = 1'b0;
  logic low_supply_flag = 1'b0;
  logic stop_exec = 1'b0;
  logic tick_period_wr = 1'b0;
  logic [3:0] tick_period_wdata = 4'h0;
  wire logic ce_pin;
  logic halt_entry_strobe, partial_init_strobe, full_init_strobe;
  logic halt_active, osc_enable, exec_start, carry_pulse;
  logic [3:0] tick_period;
  int n_fail = 0;
  int checked = 0;
  wire logic [2:0] obs = {osc_enable, full_init_strobe, exec_start};
  // Free-running system clock.
  initial forever #5 sys_clk = ~sys_clk;
  ce_host u_host (.want(ce_want), .ce_pin(ce_pin));
  reset_controller #(.MS_CYCLES(MS)) DUT (
    .sys_clk, .rst_n, .ce_pin, .low_supply_flag, .stop_exec, .tick_period_wr,
    .tick_period_wdata, .halt_entry_strobe, .partial_init_strobe, .full_init_strobe,
    .halt_active, .osc_enable, .exec_start, .carry_pulse, .tick_period
  );
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Waits a bounded time for one observed output; a hang ends the run.
  task automatic wait_hi(input int sel, input int lim, output int n);
    n = 0;
    while (obs[sel] !== 1'b1) begin
      cyc(1);
      n++;
      if (n > lim) begin
        n_fail++;
        stop_test();
      end
    end
  endtask
  // Start from address zero comes about 50 ms after the wait begins.
  task automatic wait_start(input string what);
    int n;
    wait_hi(0, 60 * MS, n);
    check(what, {3'h0, n >= 50 * MS - 5 && n <= 50 * MS + 5}, 4'h1);
  endtask
  // One-cycle stop or tick period write, sampled at the second edge.
  task automatic pulse(input logic stop, input logic wr, input logic [3:0] d);
    @(posedge sys_clk);
    stop_exec <= stop;
    tick_period_wr <= wr;
    tick_period_wdata <= d;
    @(posedge sys_clk);
    stop_exec <= 1'b0;
    tick_period_wr <= 1'b0;
    #1;
  endtask
  task automatic t_power_on();
    check("halt after reset", {3'h0, halt_active}, 4'h1);
    wait_start("power-on start");
  endtask
  task automatic t_ticks();
    int k;
    k = 0;
    for (int c = 0; c < 4; c++) begin
      pulse(1'b0, 1'b1, 4'(c));
      check("tick period", tick_period, 4'(c));
    end
    // Code 3 selects the 1 ms carry, so eight periods give eight carry pulses.
    for (int i = 0; i < 8 * MS; i++) begin
      cyc(1);
      k += int'(carry_pulse);
    end
    check("carry count", 4'(k), 4'h8);
  endtask
  task automatic t_ce_run();
    int n;
    pulse(1'b0, 1'b1, 4'h1);
    @(posedge sys_clk);
    ce_want <= 1'b1;
    wait_hi(1, 250 * MS + 8, n);
    check("aligned to carry", {3'h0, n >= 4}, 4'h1);
    check("ce strobes", {exec_start, halt_entry_strobe, partial_init_strobe}, 4'h4);
    check("running", {3'h0, halt_active}, 4'h0);
    check("tick kept", tick_period, 4'h1);
    ce_want <= 1'b0;
    cyc(5);
  endtask
  task automatic t_stop();
    int n;
    pulse(1'b1, 1'b0, 4'h0);
    check("stop strobes", {halt_entry_strobe, partial_init_strobe, full_init_strobe}, 4'h7);
    check("osc stopped", {3'h0, osc_enable}, 4'h0);
    cyc(1);
    check("tick cleared", tick_period, 4'h0);
    cyc(50 * MS);
    check("still stopped", {osc_enable, halt_active, exec_start}, 4'h2);
    @(posedge sys_clk);
    ce_want <= 1'b1;
    wait_hi(2, 8, n);
    wait_start("stop start");
    ce_want <= 1'b0;
  endtask
  task automatic t_supply();
    @(posedge sys_clk);
    low_supply_flag <= 1'b1;
    cyc(5);
    check("supply held", {halt_entry_strobe, partial_init_strobe, full_init_strobe, osc_enable}, 4'he);
    @(posedge sys_clk);
    low_supply_flag <= 1'b0;
    cyc(4);
    check("supply release", {halt_entry_strobe, partial_init_strobe, full_init_strobe, osc_enable}, 4'h1);
    wait_start("supply start");
  endtask
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    t_power_on();
    t_ticks();
    t_ce_run();
    t_stop();
    t_supply();
    stop_test();
  end
endmodule
